// ---- bench/bpf_fault_config_regs_bench.sv ----
// self-checking bench for the configuration register slice
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
    $display("FAIL t=%0t got %h exp %h", $time, (g), (e)); end end
module bpf_fault_config_regs_bench;
    logic        sys_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic        wr = 1'b0;
    logic [7:0]  wdata = 8'h00;
    logic        rd_s = 1'b0;
    logic        sync_run = 1'b0;
    logic        sync_pin;
    logic [7:0]  rdata;
    logic        hit, derate, act, ext;
    logic [4:0]  code, pct;
    logic [5:0]  volts;
    logic [1:0]  mag;
    logic [11:0] far;
    int          mismatches = 0;
    int          check_count = 0;
    always #5 sys_clk_i = ~sys_clk_i;
    bpf_sync_source u_sync (.run_i(sync_run), .pin_o(sync_pin));
    bpf_fault_config_regs uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
        .reg_hit_o(hit), .freq_set_sync_pin_i(sync_pin), .overvoltage_trip_code_o(code),
        .ovp_trip_volts_o(volts), .thermal_derate_enable_o(derate), .dither_magnitude_o(mag),
        .dither_spread_pct_o(pct), .dither_active_o(act), .ext_sync_active_o(ext),
        .fault_auto_restart_o(far));
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge sys_clk_i);
        wr = 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e, input logic h);
        @(negedge sys_clk_i);
        addr = a;
        rd_s = 1'b1;
        @(negedge sys_clk_i);
        rd_s = 1'b0;
        `CHK(rdata, e)
        `CHK(hit, h)
    endtask
    // sync detection has a long loss timeout, so the bound covers it with margin
    task automatic wait_ext(input logic v);
        int n = 0;
        while (ext !== v && n < 700) begin
            @(negedge sys_clk_i);
            n++;
        end
        if (ext !== v) begin
            mismatches++;
            $display("FAIL t=%0t sync wait expired", $time);
            final_report();
        end
    endtask
    initial begin
        repeat (5) @(negedge sys_clk_i);
        rst_i = 1'b0;
        rd_reg(8'h04, 8'h1c, 1'b1);
        `CHK(volts, 6'h24)
        rd_reg(8'h05, 8'h00, 1'b1);
        rd_reg(8'h06, 8'h0a, 1'b1);
        rd_reg(8'h07, 8'hbe, 1'b1);
        rd_reg(8'h03, 8'h00, 1'b0);
        rd_reg(8'h08, 8'h00, 1'b0);
        wr_reg(8'h04, 8'hff);
        rd_reg(8'h04, 8'h1f, 1'b1);
        `CHK(volts, 6'h27)
        `CHK(code, 5'h1f)
        wr_reg(8'h04, 8'he0);
        rd_reg(8'h04, 8'h00, 1'b1);
        `CHK(volts, 6'h08)
        `CHK(code, 5'h00)
        for (int m = 0; m < 4; m++) begin
            wr_reg(8'h05, 8'hfc | 8'(m));
            rd_reg(8'h05, 8'h04 | 8'(m), 1'b1);
            `CHK(pct, 5'(5 * m))
            `CHK(mag, 2'(m))
            `CHK(derate, 1'b1)
            `CHK(act, 1'(m != 0))
        end
        wr_reg(8'h05, 8'h00);
        `CHK(derate, 1'b0)
        wr_reg(8'h06, 8'hff);
        wr_reg(8'h07, 8'h00);
        rd_reg(8'h06, 8'h0e, 1'b1);
        rd_reg(8'h07, 8'h28, 1'b1);
        `CHK(far, 12'he28)
        wr_reg(8'h06, 8'h00);
        wr_reg(8'h07, 8'hff);
        @(negedge sys_clk_i);
        `CHK(far, 12'h0be)
        wr_reg(8'h05, 8'h03);
        sync_run = 1'b1;
        wait_ext(1'b1);
        `CHK(pct, 5'h00)
        `CHK(act, 1'b0)
        `CHK(ext, 1'b1)
        `CHK(mag, 2'h3)
        sync_run = 1'b0;
        wait_ext(1'b0);
        `CHK(pct, 5'h0f)
        `CHK(ext, 1'b0)
        `CHK(act, 1'b1)
        rst_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        rst_i = 1'b0;
        rd_reg(8'h04, 8'h1c, 1'b1);
        `CHK(far, 12'habe)
        `CHK(code, 5'h1c)
        `CHK(volts, 6'h24)
        `CHK(mag, 2'h0)
        `CHK(derate, 1'b0)
        final_report();
    end
endmodule
`default_nettype wire

// ---- bench/bpf_fault_config_regs_properties.sv ----
// port assertions for the configuration register slice
`timescale 1ns/1ps
`default_nettype none
module bpf_fault_config_regs_properties (
    input wire logic        sys_clk_i,
    input wire logic        rst_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic        reg_wr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic        reg_rd_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic        reg_hit_o,
    input wire logic [4:0]  overvoltage_trip_code_o,
    input wire logic [5:0]  ovp_trip_volts_o,
    input wire logic        thermal_derate_enable_o,
    input wire logic [1:0]  dither_magnitude_o,
    input wire logic [4:0]  dither_spread_pct_o,
    input wire logic        dither_active_o,
    input wire logic        ext_sync_active_o,
    input wire logic [11:0] fault_auto_restart_o
);
    localparam logic [11:0] FIX = ~bpf_pkg::FP_WR_MASK;
    logic [7:0] wd_q;
    logic [7:0] wd_q2;
    always_ff @(posedge sys_clk_i) begin
        wd_q  <= reg_wdata_i;
        wd_q2 <= wd_q;
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    sequence wr_at(logic [7:0] a);
        reg_wr_i && reg_addr_i == a;
    endsequence
    sequence rd_off;
        reg_rd_i && (reg_addr_i < 8'h04 || reg_addr_i > 8'h07);
    endsequence
    trip_code_write_a: assert property (wr_at(8'h04) |=> overvoltage_trip_code_o == wd_q[4:0])
        else $error("trip code not loaded");
    trip_volts_map_a: assert property (ovp_trip_volts_o == {1'b0, overvoltage_trip_code_o} + 6'h08)
        else $error("trip volts wrong");
    derate_write_a: assert property (wr_at(8'h05) |=> thermal_derate_enable_o == wd_q[2])
        else $error("derate not loaded");
    dither_write_a: assert property (wr_at(8'h05) |=> dither_magnitude_o == wd_q[1:0])
        else $error("dither code not loaded");
    spread_value_a: assert property (dither_spread_pct_o ==
        (ext_sync_active_o ? 5'h00 : {3'h0, dither_magnitude_o} * 5'h05))
        else $error("spread wrong");
    dither_gate_a: assert property (dither_active_o == (dither_magnitude_o != 2'h0 && !ext_sync_active_o))
        else $error("dither gate wrong");
    fixed_policy_a: assert property ((fault_auto_restart_o & FIX) == (bpf_pkg::FP_RESET & FIX))
        else $error("fixed policy bit moved");
    low_policy_write_a: assert property (wr_at(8'h07) |=> ##1
        (fault_auto_restart_o[7:0] & ~FIX[7:0]) == (wd_q2 & ~FIX[7:0]))
        else $error("low policy not loaded");
    high_policy_write_a: assert property (wr_at(8'h06) |=> ##1
        (fault_auto_restart_o[11:8] & ~FIX[11:8]) == (wd_q2[3:0] & ~FIX[11:8]))
        else $error("high policy not loaded");
    unmapped_read_a: assert property (rd_off |=> reg_rdata_o == 8'h00 && !reg_hit_o)
        else $error("unmapped read not empty");
endmodule
bind bpf_fault_config_regs bpf_fault_config_regs_properties u_props (.sys_clk_i(sys_clk_i),
    .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_hit_o(reg_hit_o),
    .overvoltage_trip_code_o(overvoltage_trip_code_o), .ovp_trip_volts_o(ovp_trip_volts_o),
    .thermal_derate_enable_o(thermal_derate_enable_o), .dither_magnitude_o(dither_magnitude_o),
    .dither_spread_pct_o(dither_spread_pct_o), .dither_active_o(dither_active_o),
    .ext_sync_active_o(ext_sync_active_o), .fault_auto_restart_o(fault_auto_restart_o));
`default_nettype wire

// ---- bench/bpf_sync_source.sv ----
// external sync clock source for the frequency-set pin
`timescale 1ns/1ps
`default_nettype none
module bpf_sync_source #(parameter int HALF_NS = 500) (
    input  wire logic run_i,
    output logic      pin_o
);
    // the pin holds its last level while stopped: a static pin means no sync
    initial begin
        pin_o = 1'b0;
        forever #(HALF_NS) if (run_i) pin_o = ~pin_o;
    end
endmodule
`default_nettype wire

// ---- rtl/bpf_fault_config_regs.sv ----
// boost overvoltage, dither, derate and fault policy configuration bytes
`timescale 1ns/1ps
`default_nettype none
module bpf_fault_config_regs (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_rd_i,
    output logic      [7:0]  reg_rdata_o,
    output logic             reg_hit_o,
    input  wire logic        freq_set_sync_pin_i,
    output logic      [4:0]  overvoltage_trip_code_o,
    output logic      [5:0]  ovp_trip_volts_o,
    output logic             thermal_derate_enable_o,
    output logic      [1:0]  dither_magnitude_o,
    output logic      [4:0]  dither_spread_pct_o,
    output logic             dither_active_o,
    output logic             ext_sync_active_o,
    output logic      [11:0] fault_auto_restart_o
);
    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
        addr_is = (a == ofs);
    endfunction

    // address decode
    wire logic sel_ovp;
    wire logic sel_ddr;
    wire logic sel_hi;
    wire logic sel_lo;
    wire logic sel_any;
    assign sel_ovp = addr_is(reg_addr_i, bpf_pkg::OFS_OVP);
    assign sel_ddr = addr_is(reg_addr_i, bpf_pkg::OFS_DDR);
    assign sel_hi  = addr_is(reg_addr_i, bpf_pkg::OFS_FP_HI);
    assign sel_lo  = addr_is(reg_addr_i, bpf_pkg::OFS_FP_LO);
    assign sel_any = sel_ovp | sel_ddr | sel_hi | sel_lo;

    // overvoltage trip code, only the low five bits are stored
    logic [4:0] ovp_r;
    wire  logic [4:0] ovp_nxt;
    assign ovp_nxt = (reg_wr_i && sel_ovp) ? reg_wdata_i[4:0] : ovp_r;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ovp_r <= bpf_pkg::OVP_RESET;
        end else begin
            ovp_r <= ovp_nxt;
        end
    end

    // derate enable and dither magnitude
    logic       derate_r;
    logic [1:0] dither_r;
    wire  logic       derate_nxt;
    wire  logic [1:0] dither_nxt;
    assign derate_nxt = (reg_wr_i && sel_ddr) ? reg_wdata_i[bpf_pkg::DDR_DERATE_BIT]
                                              : derate_r;
    assign dither_nxt = (reg_wr_i && sel_ddr)
                      ? reg_wdata_i[bpf_pkg::DDR_DITHER_LSB +: 2] : dither_r;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            derate_r <= bpf_pkg::DDR_DERATE_RESET;
        end else begin
            derate_r <= derate_nxt;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dither_r <= bpf_pkg::DDR_DITHER_RESET;
        end else begin
            dither_r <= dither_nxt;
        end
    end

    // fault policy store
    bpf_policy_if pol_if ();
    assign pol_if.wr_hi = reg_wr_i & sel_hi;
    assign pol_if.wr_lo = reg_wr_i & sel_lo;
    assign pol_if.wdata = reg_wdata_i;

    bpf_fault_policy_store u_policy (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .pol       (pol_if.store)
    );

    // external sync detection: three flops, level taken once the last two agree
    logic sync_meta_r;
    logic sync_s1_r;
    logic sync_s2_r;
    logic sync_lvl_r;
    logic [bpf_pkg::SYNC_CNT_W-1:0] sync_cnt_r;
    wire  logic sync_lvl_nxt;
    wire  logic sync_edge;
    wire  logic [bpf_pkg::SYNC_CNT_W-1:0] sync_lim;
    wire  logic [bpf_pkg::SYNC_CNT_W-1:0] sync_cnt_nxt;
    wire  logic ext_sync_nxt;

    assign sync_lim     = bpf_pkg::SYNC_CNT_W'(bpf_pkg::SYNC_LOSS_CYCLES);
    assign sync_lvl_nxt = (sync_s1_r == sync_s2_r) ? sync_s2_r : sync_lvl_r;
    assign sync_edge    = sync_lvl_nxt != sync_lvl_r;
    // the counter saturates, so a pin held static drops sync after the timeout
    assign sync_cnt_nxt = sync_edge ? '0
                        : (sync_cnt_r == sync_lim) ? sync_cnt_r
                        : sync_cnt_r + bpf_pkg::SYNC_CNT_W'(1);
    assign ext_sync_nxt = sync_cnt_nxt < sync_lim;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync_meta_r <= 1'h0;
            sync_s1_r   <= 1'h0;
            sync_s2_r   <= 1'h0;
            sync_lvl_r  <= 1'h0;
            sync_cnt_r  <= bpf_pkg::SYNC_CNT_W'(bpf_pkg::SYNC_LOSS_CYCLES);
        end else begin
            sync_meta_r <= freq_set_sync_pin_i;
            sync_s1_r   <= sync_meta_r;
            sync_s2_r   <= sync_s1_r;
            sync_lvl_r  <= sync_lvl_nxt;
            sync_cnt_r  <= sync_cnt_nxt;
        end
    end

    // derived settings, registered so every output leaves a flop
    wire logic [5:0] volts_nxt;
    wire logic [4:0] spread_nxt;
    wire logic       dith_act_nxt;
    assign volts_nxt    = 6'(bpf_pkg::OVP_BASE_V + bpf_pkg::OVP_STEP_V * {1'b0, ovp_nxt});
    assign dith_act_nxt = (dither_nxt != 2'h0) && !ext_sync_nxt;
    assign spread_nxt   = dith_act_nxt ? 5'(bpf_pkg::DITHER_STEP_PCT * {3'h0, dither_nxt})
                                       : 5'h00;

    // readback: unused upper bits read zero, fixed policy bits read their value
    wire logic [7:0] rd_mux;
    assign rd_mux = sel_ovp ? {3'h0, ovp_r}
                  : sel_ddr ? {5'h00, derate_r, dither_r}
                  : sel_hi  ? {4'h0, pol_if.policy[11:8]}
                  : sel_lo  ? pol_if.policy[7:0]
                  : 8'h00;

    // read data holds between reads, so a slow host engine can fetch it late
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rd_mux;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_hit_o <= 1'h0;
        end else if (reg_rd_i) begin
            reg_hit_o <= sel_any;
        end
    end

    // settings take the next values so they follow a write by one cycle
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            overvoltage_trip_code_o <= bpf_pkg::OVP_RESET;
        end else begin
            overvoltage_trip_code_o <= ovp_nxt;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ovp_trip_volts_o <= 6'(bpf_pkg::OVP_BASE_V + {1'b0, bpf_pkg::OVP_RESET});
        end else begin
            ovp_trip_volts_o <= volts_nxt;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            thermal_derate_enable_o <= bpf_pkg::DDR_DERATE_RESET;
        end else begin
            thermal_derate_enable_o <= derate_nxt;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dither_magnitude_o <= bpf_pkg::DDR_DITHER_RESET;
        end else begin
            dither_magnitude_o <= dither_nxt;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dither_spread_pct_o <= 5'h00;
        end else begin
            dither_spread_pct_o <= spread_nxt;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dither_active_o <= 1'h0;
        end else begin
            dither_active_o <= dith_act_nxt;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ext_sync_active_o <= 1'h0;
        end else begin
            ext_sync_active_o <= ext_sync_nxt;
        end
    end

    // the store is registered, so this output trails a policy write by one more cycle
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fault_auto_restart_o <= bpf_pkg::FP_RESET;
        end else begin
            fault_auto_restart_o <= pol_if.policy;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/bpf_fault_policy_store.sv ----
// twelve fault policy bits, writable or fixed per bit
`timescale 1ns/1ps
`default_nettype none
module bpf_fault_policy_store (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    bpf_policy_if.store     pol
);
    wire logic [bpf_pkg::FP_W-1:0] pol_w;

    for (genvar i = 0; i < bpf_pkg::FP_W; i++) begin : g_bit
        localparam int unsigned BI = i % 8;
        if (bpf_pkg::FP_WR_MASK[i]) begin : g_rw
            logic bit_r;
            wire logic wr_en;
            if (i >= bpf_pkg::FP_HI_LSB) begin : g_hi
                assign wr_en = pol.wr_hi;
            end else begin : g_lo
                assign wr_en = pol.wr_lo;
            end
            always_ff @(posedge sys_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    bit_r <= bpf_pkg::FP_RESET[i];
                end else if (wr_en) begin
                    bit_r <= pol.wdata[BI];
                end
            end
            assign pol_w[i] = bit_r;
        end else begin : g_ro
            // fixed for safety: no flop, so no write path can ever reach it
            assign pol_w[i] = bpf_pkg::FP_RESET[i];
        end
    end

    assign pol.policy = pol_w;
endmodule
`default_nettype wire

// ---- rtl/bpf_pkg.sv ----
// constants for the boost protection and fault policy register slice
package bpf_pkg;
    localparam int unsigned CLK_PERIOD_NS     = 10;
    localparam logic [7:0]  OFS_OVP           = 8'h04;
    localparam logic [7:0]  OFS_DDR           = 8'h05;
    localparam logic [7:0]  OFS_FP_HI         = 8'h06;
    localparam logic [7:0]  OFS_FP_LO         = 8'h07;
    localparam int unsigned OVP_CODE_W        = 5;
    localparam logic [4:0]  OVP_RESET         = 5'h1c;
    localparam logic [5:0]  OVP_BASE_V        = 6'h08;
    localparam logic [5:0]  OVP_STEP_V        = 6'h01;
    localparam int unsigned DDR_DERATE_BIT    = 2;
    localparam int unsigned DDR_DITHER_LSB    = 0;
    localparam logic        DDR_DERATE_RESET  = 1'h0;
    localparam logic [1:0]  DDR_DITHER_RESET  = 2'h0;
    localparam logic [4:0]  DITHER_STEP_PCT   = 5'h05;
    localparam int unsigned FP_W              = 12;
    localparam int unsigned FP_HI_LSB         = 8;
    localparam logic [11:0] FP_RESET          = 12'habe;
    localparam logic [11:0] FP_WR_MASK        = 12'he96;
    localparam int unsigned SYNC_LOSS_NS      = 5000;
    localparam int unsigned SYNC_LOSS_CYCLES  =
        (SYNC_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SYNC_CNT_W        = 10;
endpackage

// ---- rtl/bpf_policy_if.sv ----
// carrier between the register slice and its fault policy store
`timescale 1ns/1ps
`default_nettype none
interface bpf_policy_if;
    logic        wr_hi;
    logic        wr_lo;
    logic [7:0]  wdata;
    logic [11:0] policy;
    modport ctrl  (output wr_hi, output wr_lo, output wdata, input policy);
    modport store (input wr_hi, input wr_lo, input wdata, output policy);
endinterface
`default_nettype wire
